// >>> common/tcmr_pkg.sv
// Package with register map, field layout and types of the transceiver mode registers.
package tcmr_pkg;

  localparam logic [3:0] TCMR_OFF_SYNTH = 4'h0;
  localparam logic [3:0] TCMR_OFF_MODE = 4'h4;
  localparam logic [3:0] TCMR_OFF_STATUS = 4'h8;
  localparam logic [3:0] TCMR_OFF_FREQ = 4'hC;

  localparam logic [2:0] TCMR_SYNTH_SELECT = 3'h4;
  localparam logic [2:0] TCMR_MODE_LOW_ONES = 3'h7;
  localparam logic [1:0] TCMR_MODE_HIGH_ZEROS = 2'h0;
  localparam logic [23:0] TCMR_SYNTH_RESET = 24'h000004;
  localparam logic [23:0] TCMR_MODE_RESET = 24'h000027;

  localparam int TCMR_MODE_TX_BIT = 4;
  localparam int TCMR_MODE_RX_BIT = 3;
  localparam int TCMR_MODE_ONE_BIT = 5;

  localparam logic [1:0] TCMR_RESP_OKAY = 2'h0;
  localparam logic [1:0] TCMR_RESP_SLVERR = 2'h2;

  localparam int TCMR_REF_STEP_HZ = 50000;
  localparam int TCMR_MAIN_SCALE = 32;
  localparam int TCMR_FRAC_DIV = 8;

  typedef struct packed {
    logic [2:0] swallow_lo;
    logic [2:0] frac;
    logic [2:0] main_lo6_hi;
    logic [2:0] main_lo6_lo;
    logic [2:0] swallow_hi;
    logic [2:0] trim;
    logic [3:0] main_hi;
  } tcmr_synth_fields_t;

  typedef struct packed {
    logic [9:0] main_count;
    logic [5:0] swallow_count;
    logic [2:0] frac_count;
    logic [2:0] trim;
  } tcmr_divider_t;

  typedef enum logic [1:0] {
    TCMR_W_IDLE,
    TCMR_W_RESP
  } tcmr_wstate_t;

  typedef struct packed {
    tcmr_wstate_t wstate;
    logic aw_seen;
    logic w_seen;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [23:0] synth_word;
    logic [23:0] mode_word;
    logic [31:0] freq_hz;
  } tcmr_state_t;

endpackage

// >>> src/tcmr_regs.sv
// Transceiver synthesizer and operating mode register bank behind an AXI4-Lite slave.
//
// Chosen here: register access over AXI4-Lite and the address map.
module tcmr_regs
  import tcmr_pkg::*;
#(
  parameter int ADDR_W = 4
)
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  input wire logic slicer_data_i,
  output logic rx_data_o,
  output logic tx_section_on_o,
  output logic rx_section_on_o,
  output logic power_down_o,
  output logic xtal_enable_o,
  output tcmr_divider_t tx_divider_o,
  output logic [31:0] tx_freq_hz_o
);

  // The map decodes exactly four address bits; any other width would alias the offsets.
  if (ADDR_W != 4)
  begin : g_addr_w_check
    $error("ADDR_W must be 4 for this register map.");
  end

  tcmr_state_t state_reg;
  tcmr_state_t state_next;
  tcmr_synth_fields_t synth_f;
  tcmr_divider_t div;
  logic rx_data_reg;
  logic [23:0] wr_word;
  logic [31:0] rd_word;
  logic rd_ok;
  logic [31:0] step_count;
  logic [31:0] whole_hz;
  logic [31:0] frac_hz;

  // Field view of the stored synthesizer word.
  assign synth_f = tcmr_synth_fields_t'(
    {state_reg.synth_word[7:5], 1'b0, state_reg.synth_word[4:3],
     state_reg.synth_word[15:13], state_reg.synth_word[12:10],
     state_reg.synth_word[10:8], state_reg.synth_word[22:20],
     state_reg.synth_word[19:16]});

  // Divider counts gathered from the three bytes.
  always_comb
  begin
    div.swallow_count = {state_reg.synth_word[10:8], state_reg.synth_word[7:5]};
    // The select pattern owns bit 2, so the fraction takes only bits 4 and 3.
    div.frac_count = 3'(state_reg.synth_word[4:3]);
    div.main_count = {state_reg.synth_word[19:16], state_reg.synth_word[15:10]};
    div.trim = state_reg.synth_word[22:20];
  end

  // Terms of the divider relation, kept apart so that each product stays readable.
  always_comb
  begin
    step_count = 32'(TCMR_MAIN_SCALE) * 32'(div.main_count) + 32'(div.swallow_count);
    whole_hz = 32'(TCMR_REF_STEP_HZ) * step_count;
    frac_hz = 32'(TCMR_REF_STEP_HZ / TCMR_FRAC_DIV) * 32'(div.frac_count);
  end

  // Write word merged with byte strobes; fixed pattern bits are forced.
  always_comb
  begin
    wr_word = (state_reg.aw_addr == TCMR_OFF_MODE) ? state_reg.mode_word
                                                    : state_reg.synth_word;
    for (int b = 0; b < 3; b++)
    begin
      if (state_reg.w_strb[b])
      begin
        wr_word[8*b +: 8] = state_reg.w_data[8*b +: 8];
      end
    end
    if (state_reg.aw_addr == TCMR_OFF_MODE)
    begin
      wr_word[23:8] = 16'h0000;
      wr_word[7:6] = TCMR_MODE_HIGH_ZEROS;
      wr_word[TCMR_MODE_ONE_BIT] = 1'b1;
      wr_word[2:0] = TCMR_MODE_LOW_ONES;
    end
    else
    begin
      wr_word[2:0] = TCMR_SYNTH_SELECT;
      wr_word[23] = 1'b0;
    end
  end

  always_comb
  begin
    rd_ok = 1'b1;
    rd_word = 32'h00000000;
    unique case (s_axi_araddr_i)
      TCMR_OFF_SYNTH: rd_word = {8'h00, state_reg.synth_word};
      TCMR_OFF_MODE: rd_word = {8'h00, state_reg.mode_word};
      TCMR_OFF_STATUS: rd_word = {28'h0000000, xtal_enable_o, power_down_o,
                                  tx_section_on_o, rx_section_on_o};
      TCMR_OFF_FREQ: rd_word = state_reg.freq_hz;
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    // Whole steps and eighth steps are summed in Hz; an eighth of 50 kHz is exact.
    state_next.freq_hz = whole_hz + frac_hz;
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      state_next.aw_seen = 1'b1;
      state_next.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      state_next.w_seen = 1'b1;
      state_next.w_data = s_axi_wdata_i;
      state_next.w_strb = s_axi_wstrb_i;
    end
    unique case (state_reg.wstate)
      TCMR_W_IDLE:
      begin
        if (state_reg.aw_seen && state_reg.w_seen)
        begin
          state_next.aw_seen = 1'b0;
          state_next.w_seen = 1'b0;
          state_next.wstate = TCMR_W_RESP;
          state_next.bresp = TCMR_RESP_OKAY;
          if (state_reg.aw_addr == TCMR_OFF_SYNTH)
          begin
            state_next.synth_word = wr_word;
          end
          else if (state_reg.aw_addr == TCMR_OFF_MODE)
          begin
            state_next.mode_word = wr_word;
          end
          else if (state_reg.aw_addr != TCMR_OFF_STATUS && state_reg.aw_addr != TCMR_OFF_FREQ)
          begin
            state_next.bresp = TCMR_RESP_SLVERR;
          end
        end
      end
      TCMR_W_RESP:
      begin
        if (s_axi_bready_i)
        begin
          state_next.wstate = TCMR_W_IDLE;
        end
      end
      default: state_next.wstate = TCMR_W_IDLE;
    endcase
    if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      state_next.rvalid = 1'b1;
      state_next.rdata = rd_word;
      state_next.rresp = rd_ok ? TCMR_RESP_OKAY : TCMR_RESP_SLVERR;
    end
    else if (state_reg.rvalid && s_axi_rready_i)
    begin
      state_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_reg <= '{
        wstate: TCMR_W_IDLE,
        aw_seen: 1'b0,
        w_seen: 1'b0,
        aw_addr: 4'h0,
        w_data: 32'h00000000,
        w_strb: 4'h0,
        bresp: 2'h0,
        rvalid: 1'b0,
        rdata: 32'h00000000,
        rresp: 2'h0,
        synth_word: TCMR_SYNTH_RESET,
        mode_word: TCMR_MODE_RESET,
        freq_hz: 32'h00000000
      };
      rx_data_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
      rx_data_reg <= slicer_data_i;
    end
  end

  // The write channels stall while a captured beat waits, so writes never overrun.
  assign s_axi_awready_o = !state_reg.aw_seen && state_reg.wstate == TCMR_W_IDLE && ce_i;
  assign s_axi_wready_o = !state_reg.w_seen && state_reg.wstate == TCMR_W_IDLE && ce_i;
  assign s_axi_bvalid_o = state_reg.wstate == TCMR_W_RESP;
  assign s_axi_bresp_o = state_reg.bresp;
  assign s_axi_arready_o = !state_reg.rvalid && ce_i;
  assign s_axi_rvalid_o = state_reg.rvalid;
  assign s_axi_rdata_o = state_reg.rdata;
  assign s_axi_rresp_o = state_reg.rresp;

  assign rx_data_o = rx_data_reg;
  assign tx_section_on_o = state_reg.mode_word[TCMR_MODE_TX_BIT];
  assign rx_section_on_o = state_reg.mode_word[TCMR_MODE_RX_BIT];
  assign power_down_o = !tx_section_on_o && !rx_section_on_o;
  assign xtal_enable_o = tx_section_on_o || rx_section_on_o;
  assign tx_divider_o = div;
  assign tx_freq_hz_o = state_reg.freq_hz;

  // The field view feeds no logic beyond documentation of layout.
  logic unused_fields;
  assign unused_fields = ^synth_f;

endmodule

// >>> testbench/tcmr_regs_properties.sv
// Checker of the port behaviour of the transceiver mode register bank.
module tcmr_regs_properties
  import tcmr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic slicer_data_i,
  input wire logic rx_data_o,
  input wire logic tx_section_on_o,
  input wire logic rx_section_on_o,
  input wire logic power_down_o,
  input wire logic xtal_enable_o,
  input wire tcmr_divider_t tx_divider_o,
  input wire logic [31:0] tx_freq_hz_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // The fraction is in eighths of a step, so it adds step/8 Hz per count.
  wire logic [31:0] freq_law = TCMR_REF_STEP_HZ * (TCMR_MAIN_SCALE * tx_divider_o.main_count
    + tx_divider_o.swallow_count) + TCMR_REF_STEP_HZ / TCMR_FRAC_DIV * tx_divider_o.frac_count;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  a_pd_both_off: assert property (power_down_o == (!tx_section_on_o && !rx_section_on_o))
    else $error("power down does not follow the section bits");
  a_xtal_either_on: assert property (xtal_enable_o == (tx_section_on_o || rx_section_on_o))
    else $error("crystal enable does not follow the section bits");
  // Attempts start only out of reset, since the first cycle after release still shows reset values.
  a_slicer_copy: assert property (rstn_i && ce_i |=> rx_data_o == $past(slicer_data_i))
    else $error("receive data is not the slicer bit of the previous cycle");
  a_freq_law: assert property (rstn_i && ce_i |=> tx_freq_hz_o == $past(freq_law))
    else $error("frequency does not match the divider counts");
  a_tx_on_write: assert property ($changed(tx_section_on_o) |-> $rose(s_axi_bvalid_o))
    else $error("transmitter bit changed without a write");
  a_rx_on_write: assert property ($changed(rx_section_on_o) |-> $rose(s_axi_bvalid_o))
    else $error("receiver bit changed without a write");
  a_ce_freeze: assert property (!ce_i |-> !s_axi_awready_o && !s_axi_wready_o && !s_axi_arready_o)
    else $error("ready high while clock enable is low");
  a_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
    && $stable(s_axi_bresp_o)) else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
    && $stable(s_axi_rdata_o)) else $error("read data dropped early");
  c_power_down: cover property ($rose(power_down_o));
  c_both_on: cover property (tx_section_on_o && rx_section_on_o);
  c_ce_low: cover property ($fell(ce_i));
endmodule
bind tcmr_regs tcmr_regs_properties tcmr_regs_properties_i (.*);

// >>> testbench/tcmr_host.sv
// Host model that programs the register bank over AXI4-Lite and times its settling waits.
module tcmr_host
#(
  parameter int SETTLE_CYC = 200
)
(
  input wire logic mclk_i,
  output logic awvalid_o = 1'b0,
  output logic [3:0] awaddr_o = 4'h0,
  output logic wvalid_o = 1'b0,
  output logic [31:0] wdata_o = 32'h0,
  output logic [3:0] wstrb_o = 4'hF,
  output logic bready_o = 1'b0,
  output logic arvalid_o = 1'b0,
  output logic [3:0] araddr_o = 4'h0,
  output logic rready_o = 1'b0,
  input wire logic awready_i,
  input wire logic wready_i,
  input wire logic bvalid_i,
  input wire logic [1:0] bresp_i,
  input wire logic arready_i,
  input wire logic rvalid_i,
  input wire logic [31:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic stuck = 1'b0;
  // No lock flag exists, so the host counts the settling time; scaled down for run length.
  task automatic settle();
    repeat (SETTLE_CYC) @(posedge mclk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk_i);
    awaddr_o <= a;
    wdata_o <= d;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge mclk_i);
      if (!awvalid_o && !wvalid_o && bvalid_i)
        break;
      awvalid_o <= awvalid_o && !awready_i;
      wvalid_o <= wvalid_o && !wready_i;
    end
    r = bresp_i;
    bready_o <= 1'b0;
    stuck = stuck || n == 50;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    @(posedge mclk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge mclk_i);
      if (!arvalid_o && rvalid_i)
        break;
      arvalid_o <= arvalid_o && !arready_i;
    end
    d = rdata_i;
    rready_o <= 1'b0;
    stuck = stuck || n == 50;
  endtask
endmodule

// >>> testbench/tcmr_regs_tb.sv
// Self-checking bench of the transceiver mode register bank.
module tcmr_regs_tb import tcmr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1, slicer_data_i = 1'b0;
  logic s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
  logic [3:0] s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, tx_freq_hz_o, d;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
  logic rx_data_o, tx_section_on_o, rx_section_on_o, power_down_o, xtal_enable_o;
  tcmr_divider_t tx_divider_o;
  int n_fail = 0;
  int n_compared = 0;
  always #5 mclk_i = ~mclk_i;
  // The far host sends at about 19.2 kbps, one slicer bit every BIT_CYC clocks.
  localparam int BIT_CYC = 5209;
  int bit_cnt = 0;
  int n_wait = 0;
  always @(posedge mclk_i)
  begin
    bit_cnt <= (bit_cnt == BIT_CYC - 1) ? 0 : bit_cnt + 1;
    if (bit_cnt == BIT_CYC - 1)
      slicer_data_i <= !slicer_data_i;
  end
  tcmr_regs tcmr_regs_i (.*);
  tcmr_host tcmr_host_i (.mclk_i(mclk_i), .awvalid_o(s_axi_awvalid_i), .awaddr_o(s_axi_awaddr_i),
    .wvalid_o(s_axi_wvalid_i), .wdata_o(s_axi_wdata_i), .wstrb_o(s_axi_wstrb_i),
    .bready_o(s_axi_bready_i), .arvalid_o(s_axi_arvalid_i), .araddr_o(s_axi_araddr_i),
    .rready_o(s_axi_rready_i), .awready_i(s_axi_awready_o), .wready_i(s_axi_wready_o),
    .bvalid_i(s_axi_bvalid_o), .bresp_i(s_axi_bresp_o), .arready_i(s_axi_arready_o),
    .rvalid_i(s_axi_rvalid_o), .rdata_i(s_axi_rdata_o));
  task conclude();
    if (n_fail == 0 && n_compared > 0 && !tcmr_host_i.stuck)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %0t saw %h expected %h", $time, s, e);
    end
    if (tcmr_host_i.stuck)
      conclude();
  endtask
  initial
  begin
    repeat (16) @(posedge mclk_i);
    rstn_i <= 1'b1;
    tcmr_host_i.rd(TCMR_OFF_SYNTH, d);
    chk(d, 32'h00000004);
    chk(s_axi_rresp_o, TCMR_RESP_OKAY);
    tcmr_host_i.rd(TCMR_OFF_MODE, d);
    chk(d, 32'h00000027);
    chk(power_down_o, 1'h1);
    // Forced pattern bits and lane 3 are written wrong on purpose.
    tcmr_host_i.wr(TCMR_OFF_SYNTH, 32'hAB290B07, r);
    chk(r, TCMR_RESP_OKAY);
    tcmr_host_i.rd(TCMR_OFF_SYNTH, d);
    chk(d, 32'h00290B04);
    chk(tx_divider_o, {10'h242, 6'h18, 3'h0, 3'h2});
    chk(tx_freq_hz_o, 32'h3731A380);
    for (int m = 0; m < 4; m++)
    begin
      tcmr_host_i.wr(TCMR_OFF_MODE, 32'hFFFFFFC0 | (m << 3), r);
      tcmr_host_i.settle();
      tcmr_host_i.rd(TCMR_OFF_MODE, d);
      chk(d, 32'h00000027 | (m << 3));
      chk(tx_section_on_o, m[1]);
      chk(rx_section_on_o, m[0]);
      tcmr_host_i.rd(TCMR_OFF_STATUS, d);
      chk(d, {28'h0, m != 0, m == 0, m[1:0]});
    end
    tcmr_host_i.wr(TCMR_OFF_STATUS, 32'h0, r);
    chk(r, TCMR_RESP_OKAY);
    tcmr_host_i.wr(4'h6, 32'hFFFFFFFF, r);
    chk(r, TCMR_RESP_SLVERR);
    tcmr_host_i.rd(4'h2, d);
    chk(d, 32'h00000000);
    chk(s_axi_rresp_o, TCMR_RESP_SLVERR);
    tcmr_host_i.rd(TCMR_OFF_MODE, d);
    chk(d, 32'h0000003F);
    ce_i <= 1'b0;
    fork
      tcmr_host_i.wr(TCMR_OFF_MODE, 32'h0, r);
      begin
        repeat (6) @(posedge mclk_i);
        ce_i <= 1'b1;
      end
    join
    chk(power_down_o, 1'h1);
    chk(xtal_enable_o, 1'h0);
    // Wait for a slicer bit change, then see the receive output follow one clock later.
    do
    begin
      @(posedge mclk_i);
      #1;
      n_wait++;
    end
    while (bit_cnt != 0 && n_wait < BIT_CYC + 2);
    chk(bit_cnt, 0);
    chk(rx_data_o, !slicer_data_i);
    @(posedge mclk_i);
    #1;
    chk(rx_data_o, slicer_data_i);
    conclude();
  end
endmodule
